// ### rtl/srfu_defines.vh
`ifndef SRFU_DEFINES_VH
`define SRFU_DEFINES_VH

// ----------------------------------------------------------------
// operation codes presented on op_code_in
// ----------------------------------------------------------------
`define SRFU_OP_W          5
`define SRFU_OP_NOP        5'h00
`define SRFU_OP_LSHL       5'h01
`define SRFU_OP_LSHR       5'h02
`define SRFU_OP_ROTL       5'h03
`define SRFU_OP_ROTR       5'h04
`define SRFU_OP_ASHR       5'h05
`define SRFU_OP_SWAP       5'h06
`define SRFU_OP_FSET       5'h07
`define SRFU_OP_FCLR       5'h08
`define SRFU_OP_BSTORE     5'h09
`define SRFU_OP_BLOAD      5'h0a
`define SRFU_OP_SET_C      5'h0b
`define SRFU_OP_CLR_C      5'h0c
`define SRFU_OP_SET_N      5'h0d
`define SRFU_OP_CLR_N      5'h0e
`define SRFU_OP_SET_Z      5'h0f
`define SRFU_OP_CLR_Z      5'h10
`define SRFU_OP_SET_I      5'h11
`define SRFU_OP_CLR_I      5'h12
`define SRFU_OP_SET_S      5'h13
`define SRFU_OP_CLR_S      5'h14
`define SRFU_OP_SET_V      5'h15
`define SRFU_OP_CLR_V      5'h16
`define SRFU_OP_SET_T      5'h17
`define SRFU_OP_CLR_T      5'h18
`define SRFU_OP_CLR_H      5'h19
`define SRFU_OP_SLEEP      5'h1a
`define SRFU_OP_WDOG       5'h1b
`define SRFU_OP_BREAK      5'h1c

// ----------------------------------------------------------------
// status flag bit positions
// ----------------------------------------------------------------
`define SRFU_FLAG_C        3'h0
`define SRFU_FLAG_Z        3'h1
`define SRFU_FLAG_N        3'h2
`define SRFU_FLAG_V        3'h3
`define SRFU_FLAG_S        3'h4
`define SRFU_FLAG_H        3'h5
`define SRFU_FLAG_T        3'h6
`define SRFU_FLAG_I        3'h7
`define SRFU_MSB           3'h7
`define SRFU_LSB           3'h0

// ----------------------------------------------------------------
// register port map and reset values
// ----------------------------------------------------------------
`define SRFU_ADDR_W        2
`define SRFU_ADDR_STATUS   2'h0
`define SRFU_ADDR_RESULT   2'h1
`define SRFU_ADDR_CTRL     2'h2
`define SRFU_ADDR_OPCOUNT  2'h3
`define SRFU_CTRL_BRK_EN   0
`define SRFU_STATUS_RST    8'h00
`define SRFU_CTRL_RST      8'h01
`define SRFU_ZERO8         8'h00
`define SRFU_ONE8          8'h01

`endif

// ### rtl/srfu_shifter.v
`timescale 1ns/1ps
`include "srfu_defines.vh"

// ----------------------------------------------------------------
// one-cycle shift and rotate datapath with flag results
// ----------------------------------------------------------------
module srfu_shifter (
  input  wire [`SRFU_OP_W-1:0] op_in,
  input  wire [7:0]            operand_in,
  input  wire                  carry_in,
  output reg  [7:0]            result_out,
  output reg                   carry_out,
  output wire                  zero_out,
  output wire                  neg_out,
  output wire                  ovf_out
);

  always @* begin
    result_out = operand_in;
    carry_out  = carry_in;
    case (op_in)
      `SRFU_OP_LSHL: begin
        result_out = {operand_in[6:0], 1'b0};
        carry_out  = operand_in[`SRFU_MSB];
      end
      `SRFU_OP_LSHR: begin
        result_out = {1'b0, operand_in[7:1]};
        carry_out  = operand_in[`SRFU_LSB];
      end
      `SRFU_OP_ROTL: begin
        result_out = {operand_in[6:0], carry_in};
        carry_out  = operand_in[`SRFU_MSB];
      end
      `SRFU_OP_ROTR: begin
        result_out = {carry_in, operand_in[7:1]};
        carry_out  = operand_in[`SRFU_LSB];
      end
      `SRFU_OP_ASHR: begin
        result_out = {operand_in[7], operand_in[7:1]};
        carry_out  = operand_in[`SRFU_LSB];
      end
      default: begin
        result_out = operand_in;
        carry_out  = carry_in;
      end
    endcase
  end

  assign zero_out = (result_out == `SRFU_ZERO8);
  assign neg_out  = result_out[`SRFU_MSB];
  // overflow after a one-place shift is n xor c, which is the sign change for the left shifts only
  assign ovf_out  = neg_out ^ carry_out;

endmodule // srfu_shifter

// ### rtl/srfu_core.v
// Overview of operation
// - left shift: bits up, zero in, flags
// - right shift: bits down, zero top, flags
// - rotate left: carry in bit0, bit7 out
// - rotate right: carry in bit7, bit0 out
// - arithmetic right shift keeps the sign bit
// - nibble swap, flags untouched
// - selected register bit copied to transfer flag
// - transfer flag written into selected register bit
// - overflow flag set and clear
// - signed test flag set and clear only
// - transfer flag set and clear
// - half carry clear, nothing else touched
// - sleep: one clock, requests low-power function
// - watchdog restart: one clock, pulses restart
// - break: debug only, flags untouched
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "srfu_defines.vh"

module srfu_core #(
  parameter CNT_W = 16
) (
  input  wire                    clk_in,
  input  wire                    reset_in,
  input  wire                    ce_in,
  input  wire                    op_valid_in,
  input  wire [`SRFU_OP_W-1:0]   op_code_in,
  input  wire [7:0]              operand_in,
  input  wire [2:0]              bit_sel_in,
  input  wire [`SRFU_ADDR_W-1:0] reg_addr_in,
  input  wire [7:0]              reg_wdata_in,
  input  wire                    reg_wr_in,
  input  wire                    reg_rd_in,
  output reg  [7:0]              reg_rdata_out,
  output reg  [7:0]              result_out,
  output reg                     result_wr_out,
  output reg  [7:0]              status_flags_out,
  output reg                     pc_advance_out,
  output reg                     sleep_req_out,
  output reg                     watchdog_restart_out,
  output reg                     break_req_out
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // replace one bit of a byte; used for register bit load and flag ops
  function [7:0] put_bit;
    input [7:0] value;
    input [2:0] idx;
    input       bit_val;
    reg   [7:0] mask;
    begin
      mask    = `SRFU_ONE8 << idx;
      put_bit = bit_val ? (value | mask) : (value & ~mask);
    end
  endfunction

  // dedicated single-flag ops: {hit, flag index, new value}
  function [4:0] flag_op_decode;
    input [`SRFU_OP_W-1:0] op;
    begin
      case (op)
        `SRFU_OP_SET_C: flag_op_decode = {1'b1, `SRFU_FLAG_C, 1'b1};
        `SRFU_OP_CLR_C: flag_op_decode = {1'b1, `SRFU_FLAG_C, 1'b0};
        `SRFU_OP_SET_N: flag_op_decode = {1'b1, `SRFU_FLAG_N, 1'b1};
        `SRFU_OP_CLR_N: flag_op_decode = {1'b1, `SRFU_FLAG_N, 1'b0};
        `SRFU_OP_SET_Z: flag_op_decode = {1'b1, `SRFU_FLAG_Z, 1'b1};
        `SRFU_OP_CLR_Z: flag_op_decode = {1'b1, `SRFU_FLAG_Z, 1'b0};
        `SRFU_OP_SET_I: flag_op_decode = {1'b1, `SRFU_FLAG_I, 1'b1};
        `SRFU_OP_CLR_I: flag_op_decode = {1'b1, `SRFU_FLAG_I, 1'b0};
        `SRFU_OP_SET_S: flag_op_decode = {1'b1, `SRFU_FLAG_S, 1'b1};
        `SRFU_OP_CLR_S: flag_op_decode = {1'b1, `SRFU_FLAG_S, 1'b0};
        `SRFU_OP_SET_V: flag_op_decode = {1'b1, `SRFU_FLAG_V, 1'b1};
        `SRFU_OP_CLR_V: flag_op_decode = {1'b1, `SRFU_FLAG_V, 1'b0};
        `SRFU_OP_SET_T: flag_op_decode = {1'b1, `SRFU_FLAG_T, 1'b1};
        `SRFU_OP_CLR_T: flag_op_decode = {1'b1, `SRFU_FLAG_T, 1'b0};
        `SRFU_OP_CLR_H: flag_op_decode = {1'b1, `SRFU_FLAG_H, 1'b0};
        // codes with no single-flag action land here, unknown codes too
        default:        flag_op_decode = {1'b0, `SRFU_FLAG_C, 1'b0};
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [7:0]       status_flags_reg_ff;
  reg  [7:0]       nxt_status_flags_reg;
  reg  [7:0]       ctrl_ff;
  reg  [CNT_W-1:0] op_count_ff;
  reg  [7:0]       nxt_result;
  reg              nxt_result_wr;
  reg              nxt_pc_advance;
  reg              nxt_sleep_req;
  reg              nxt_watchdog_restart;
  reg              nxt_break_req;
  reg  [7:0]       nxt_rdata;

  wire [7:0]       shift_result;
  wire             shift_carry;
  wire             shift_zero;
  wire             shift_neg;
  wire             shift_ovf;
  wire [4:0]       flag_op;
  wire             op_go;
  wire             brk_enabled;

  // ce_in is applied at the flops, so op_go may rise while the core is
  // frozen; nothing it selects is stored until ce_in returns
  assign op_go       = op_valid_in;
  assign flag_op     = flag_op_decode(op_code_in);
  assign brk_enabled = ctrl_ff[`SRFU_CTRL_BRK_EN];

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  // words: status flags (rw), last result (ro), control (rw, bit 0 lets
  // a break halt the core) and the low byte of the executed-op count
  // (ro); writes to the read-only words are dropped without notice
  wire             wr_status;
  wire             wr_ctrl;
  wire             status_wr_ok;

  assign wr_status    = reg_wr_in && (reg_addr_in == `SRFU_ADDR_STATUS);
  assign wr_ctrl      = reg_wr_in && (reg_addr_in == `SRFU_ADDR_CTRL);
  // any valid op owns the flags in its cycle, even one that leaves them
  // alone; software must not write the flags beside an op
  assign status_wr_ok = wr_status && !op_go;

  // ----------------------------------------------------------------
  // shift and rotate datapath
  // ----------------------------------------------------------------
  srfu_shifter u_shifter (
    .op_in      (op_code_in),
    .operand_in (operand_in),
    .carry_in   (status_flags_reg_ff[`SRFU_FLAG_C]),
    .result_out (shift_result),
    .carry_out  (shift_carry),
    .zero_out   (shift_zero),
    .neg_out    (shift_neg),
    .ovf_out    (shift_ovf)
  );

  // ----------------------------------------------------------------
  // operation execution
  // ----------------------------------------------------------------
  // an executing operation wins over a software write to the status
  // register in the same cycle, so no flag result is ever lost
  always @* begin
    nxt_status_flags_reg = status_flags_reg_ff;
    nxt_result           = result_out;
    nxt_result_wr        = 1'b0;
    nxt_pc_advance       = 1'b0;
    nxt_sleep_req        = 1'b0;
    nxt_watchdog_restart = 1'b0;
    nxt_break_req        = 1'b0;
    if (status_wr_ok) begin
      nxt_status_flags_reg = reg_wdata_in;
    end
    if (op_go) begin
      nxt_pc_advance = 1'b1;
      case (op_code_in)
        `SRFU_OP_LSHL, `SRFU_OP_LSHR, `SRFU_OP_ROTL,
        `SRFU_OP_ROTR, `SRFU_OP_ASHR: begin
          nxt_result    = shift_result;
          nxt_result_wr = 1'b1;
          nxt_status_flags_reg = status_flags_reg_ff;
          // s, h, t and i are not defined by a shift and keep their value
          nxt_status_flags_reg[`SRFU_FLAG_C] = shift_carry;
          nxt_status_flags_reg[`SRFU_FLAG_Z] = shift_zero;
          nxt_status_flags_reg[`SRFU_FLAG_N] = shift_neg;
          nxt_status_flags_reg[`SRFU_FLAG_V] = shift_ovf;
        end
        `SRFU_OP_SWAP: begin
          nxt_result    = {operand_in[3:0], operand_in[7:4]};
          nxt_result_wr = 1'b1;
          nxt_status_flags_reg = status_flags_reg_ff;
        end
        `SRFU_OP_BSTORE: begin
          // only t moves; the other flags are rebuilt from their old value
          nxt_status_flags_reg = put_bit(status_flags_reg_ff, `SRFU_FLAG_T,
                                         operand_in[bit_sel_in]);
        end
        `SRFU_OP_BLOAD: begin
          nxt_result    = put_bit(operand_in, bit_sel_in,
                                  status_flags_reg_ff[`SRFU_FLAG_T]);
          nxt_result_wr = 1'b1;
          nxt_status_flags_reg = status_flags_reg_ff;
        end
        `SRFU_OP_FSET: begin
          nxt_status_flags_reg = put_bit(status_flags_reg_ff, bit_sel_in, 1'b1);
        end
        `SRFU_OP_FCLR: begin
          nxt_status_flags_reg = put_bit(status_flags_reg_ff, bit_sel_in, 1'b0);
        end
        `SRFU_OP_SLEEP: begin
          nxt_sleep_req        = 1'b1;
          nxt_status_flags_reg = status_flags_reg_ff;
        end
        `SRFU_OP_WDOG: begin
          nxt_watchdog_restart = 1'b1;
          nxt_status_flags_reg = status_flags_reg_ff;
        end
        `SRFU_OP_BREAK: begin
          // the debugger owns the program counter after a break; with the
          // debug link disabled the break behaves as a plain no-op
          nxt_break_req        = brk_enabled;
          nxt_pc_advance       = ~brk_enabled;
          nxt_status_flags_reg = status_flags_reg_ff;
        end
        `SRFU_OP_NOP: begin
          nxt_status_flags_reg = status_flags_reg_ff;
        end
        default: begin
          if (flag_op[4]) begin
            nxt_status_flags_reg = put_bit(status_flags_reg_ff, flag_op[3:1], flag_op[0]);
          end else begin
            // unknown codes only advance the program counter
            nxt_status_flags_reg = status_flags_reg_ff;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register port read mux
  // ----------------------------------------------------------------
  // the mux settles every cycle; only the read strobe latches it
  always @* begin
    if (reg_addr_in == `SRFU_ADDR_STATUS) begin
      nxt_rdata = status_flags_reg_ff;
    end else if (reg_addr_in == `SRFU_ADDR_RESULT) begin
      nxt_rdata = result_out;
    end else if (reg_addr_in == `SRFU_ADDR_CTRL) begin
      nxt_rdata = ctrl_ff;
    end else begin
      nxt_rdata = op_count_ff[7:0];
    end
  end

  // ----------------------------------------------------------------
  // state flip-flops
  // ----------------------------------------------------------------
  // reset ignores ce_in so the core always starts clean; while ce_in is
  // low every flop holds, and an op offered then is lost, not queued
  always @(posedge clk_in) begin
    if (reset_in) begin
      status_flags_reg_ff <= `SRFU_STATUS_RST;
      ctrl_ff             <= `SRFU_CTRL_RST;
      op_count_ff         <= {CNT_W{1'b0}};
    end else if (ce_in) begin
      status_flags_reg_ff <= nxt_status_flags_reg;
      if (wr_ctrl) begin
        ctrl_ff <= reg_wdata_in;
      end
      // counter wraps; it only helps software watch progress
      if (op_go) begin
        op_count_ff <= op_count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ----------------------------------------------------------------
  // output flip-flops
  // ----------------------------------------------------------------
  // a pulse that is high when ce_in drops stays high until ce_in returns
  always @(posedge clk_in) begin
    if (reset_in) begin
      result_out           <= `SRFU_ZERO8;
      result_wr_out        <= 1'b0;
      pc_advance_out       <= 1'b0;
      sleep_req_out        <= 1'b0;
      watchdog_restart_out <= 1'b0;
      break_req_out        <= 1'b0;
      reg_rdata_out        <= `SRFU_ZERO8;
    end else if (ce_in) begin
      result_out           <= nxt_result;
      result_wr_out        <= nxt_result_wr;
      pc_advance_out       <= nxt_pc_advance;
      sleep_req_out        <= nxt_sleep_req;
      watchdog_restart_out <= nxt_watchdog_restart;
      break_req_out        <= nxt_break_req;
      // read data stands only in the cycle after the strobe
      reg_rdata_out <= reg_rd_in ? nxt_rdata : `SRFU_ZERO8;
    end
  end

  // ----------------------------------------------------------------
  // status output
  // ----------------------------------------------------------------
  // the flags leave straight from their flops with no logic in between
  always @* begin
    status_flags_out = status_flags_reg_ff;
  end

endmodule // srfu_core

// ### bench/srfu_regfile_model.sv
`timescale 1ns/1ps

// ------
// far side: one general register feeding the operand port
// ------
module srfu_regfile_model (
  input  wire logic       clk_in,
  input  wire logic       req_in,
  input  wire logic       load_in,
  input  wire logic [7:0] load_val_in,
  input  wire logic [7:0] result_in,
  input  wire logic       result_wr_in,
  output wire logic       op_valid_out,
  output wire logic [7:0] operand_out
);
  logic [7:0] rf_ff = 8'h00;

  assign op_valid_out = req_in;
  // outside an op the byte is inverted, so a late sample cannot pass by luck
  assign operand_out  = req_in ? rf_ff : ~rf_ff;

  always @(posedge clk_in) begin
    if (load_in)
      rf_ff <= load_val_in;
    else if (result_wr_in)
      rf_ff <= result_in;
  end
endmodule // srfu_regfile_model

// ### bench/srfu_core_chk.sv
`timescale 1ns/1ps
`include "srfu_defines.vh"

module srfu_core_chk (
  input wire logic       clk_in,
  input wire logic       reset_in,
  input wire logic       ce_in,
  input wire logic       op_valid_in,
  input wire logic [4:0] op_code_in,
  input wire logic [7:0] operand_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic [7:0] result_out,
  input wire logic [7:0] status_flags_out,
  input wire logic       sleep_req_out,
  input wire logic       watchdog_restart_out
);
  // ------
  // helpers
  // ------
  wire op_go = ce_in && op_valid_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);

  chk_lshl_value: assert property (op_go && op_code_in == `SRFU_OP_LSHL |=>
    result_out == {$past(operand_in[6:0]), 1'b0} && status_flags_out[0] == $past(operand_in[7]))
    else $error("left shift wrong");
  chk_lshr_value: assert property (op_go && op_code_in == `SRFU_OP_LSHR |=>
    result_out == {1'b0, $past(operand_in[7:1])} && status_flags_out[0] == $past(operand_in[0])
    && status_flags_out[3] == (status_flags_out[2] ^ status_flags_out[0]))
    else $error("right shift wrong");
  chk_rotl_carry: assert property (op_go && op_code_in == `SRFU_OP_ROTL |=>
    result_out == {$past(operand_in[6:0]), $past(status_flags_out[0])})
    else $error("rotate left wrong");
  chk_rotr_carry: assert property (op_go && op_code_in == `SRFU_OP_ROTR |=>
    result_out == {$past(status_flags_out[0]), $past(operand_in[7:1])}
    && status_flags_out[0] == $past(operand_in[0])) else $error("rotate right wrong");
  chk_ashr_sign: assert property (op_go && op_code_in == `SRFU_OP_ASHR |=>
    result_out == {$past(operand_in[7]), $past(operand_in[7:1])}) else $error("arith shift");
  chk_swap_flags: assert property (op_go && op_code_in == `SRFU_OP_SWAP |=>
    result_out == {$past(operand_in[3:0]), $past(operand_in[7:4])} && $stable(status_flags_out))
    else $error("swap wrong");
  chk_bstore_only: assert property (op_go && op_code_in == `SRFU_OP_BSTORE |=>
    status_flags_out[6] == $past(operand_in[bit_sel_in])
    && status_flags_out[7] == $past(status_flags_out[7])
    && status_flags_out[5:0] == $past(status_flags_out[5:0])) else $error("bit store wrong");
  chk_fset_index: assert property (op_go && op_code_in == `SRFU_OP_FSET |=>
    status_flags_out == ($past(status_flags_out) | (8'h01 << $past(bit_sel_in))))
    else $error("indexed flag set wrong");
  chk_fclr_index: assert property (op_go && op_code_in == `SRFU_OP_FCLR |=>
    status_flags_out == ($past(status_flags_out) & ~(8'h01 << $past(bit_sel_in))))
    else $error("indexed flag clear wrong");
  chk_sleep_pulse: assert property (op_go && op_code_in == `SRFU_OP_SLEEP |=>
    sleep_req_out && $stable(status_flags_out)) else $error("sleep request missing");
  chk_wdog_pulse: assert property (op_go && op_code_in == `SRFU_OP_WDOG |=>
    watchdog_restart_out && $stable(status_flags_out)) else $error("watchdog restart missing");
  chk_nop_quiet: assert property (op_go && op_code_in == `SRFU_OP_NOP |=>
    $stable(status_flags_out) && $stable(result_out)) else $error("no-op changed state");
endmodule // srfu_core_chk

bind srfu_core srfu_core_chk srfu_core_chk_i (.clk_in(clk_in), .reset_in(reset_in),
  .ce_in(ce_in), .op_valid_in(op_valid_in), .op_code_in(op_code_in), .operand_in(operand_in),
  .bit_sel_in(bit_sel_in), .result_out(result_out), .status_flags_out(status_flags_out),
  .sleep_req_out(sleep_req_out), .watchdog_restart_out(watchdog_restart_out));

// ### bench/srfu_core_tb.sv
`timescale 1ns/1ps
`include "srfu_defines.vh"

module srfu_core_tb;
  logic       clk_in = 0, reset_in = 1, ce_in = 1, req = 0, ld = 0, wr = 0, rd = 0, set;
  logic [4:0] code = 0, c;
  logic [2:0] sel = 0;
  logic [1:0] addr = 0;
  logic [7:0] wdata = 0, ldv = 0, rdata, res, flags, f, e, operand;
  logic       op_valid, res_wr, pc_adv, slp, wdg, brk;
  logic [15:0] x;
  logic [2:0] pos [8] = '{3'h0, 3'h2, 3'h1, 3'h7, 3'h4, 3'h3, 3'h6, 3'h5};
  logic [7:0] pat [3] = '{8'h81, 8'h01, 8'h40};
  int         failures = 0, num_checks = 0, k, v, b;

  always #12.5 clk_in = ~clk_in;

  srfu_regfile_model srfu_regfile_model_i (.clk_in(clk_in), .req_in(req), .load_in(ld),
    .load_val_in(ldv), .result_in(res), .result_wr_in(res_wr), .op_valid_out(op_valid),
    .operand_out(operand));
  srfu_core srfu_core_i (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in),
    .op_valid_in(op_valid), .op_code_in(code), .operand_in(operand), .bit_sel_in(sel),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .result_out(res), .result_wr_out(res_wr),
    .status_flags_out(flags), .pc_advance_out(pc_adv), .sleep_req_out(slp),
    .watchdog_restart_out(wdg), .break_req_out(brk));

  // ------
  // access tasks
  // ------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  // register is loaded a cycle ahead so the operand is settled when the op is taken
  task automatic op(input logic [4:0] cd, input logic [2:0] s, input logic [7:0] val);
    @(posedge clk_in);
    ld <= 1;
    ldv <= val;
    @(posedge clk_in);
    ld <= 0;
    req <= 1;
    code <= cd;
    sel <= s;
    @(posedge clk_in);
    req <= 0;
    #1;
  endtask

  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk_in);
    wr <= 0;
  endtask

  task automatic rreg(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    rd <= 1;
    addr <= a;
    @(posedge clk_in);
    rd <= 0;
    #1 chk(rdata, exp);
  endtask

  task automatic ctl(input logic [4:0] cd, input logic [3:0] ex);
    op(cd, 3'h0, 8'h3c);
    chk({4'h0, slp, wdg, brk, pc_adv}, {4'h0, ex});
    chk(flags, 8'h5a);
  endtask

  function automatic logic [15:0] ref_op(input logic [4:0] cd, input logic [7:0] a,
                                         input logic [7:0] fl);
    logic [7:0] r;
    logic       cy;
    r = {a[3:0], a[7:4]};
    cy = a[0];
    case (cd)
      `SRFU_OP_LSHL: begin
        r = {a[6:0], 1'b0};
        cy = a[7];
      end
      `SRFU_OP_LSHR: r = {1'b0, a[7:1]};
      `SRFU_OP_ROTL: begin
        r = {a[6:0], fl[0]};
        cy = a[7];
      end
      `SRFU_OP_ROTR: r = {fl[0], a[7:1]};
      `SRFU_OP_ASHR: r = {a[7], a[7:1]};
      default: return {fl, r};
    endcase
    return {fl[7:4], r[7] ^ cy, r[7], r == 8'h00, cy, r};
  endfunction

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #2000000;
    failures++;
    report_and_stop;
  end

  // ------
  // tests
  // ------
  initial begin
    repeat (5) @(posedge clk_in);
    reset_in <= 0;
    rreg(`SRFU_ADDR_STATUS, `SRFU_STATUS_RST);
    rreg(`SRFU_ADDR_CTRL, `SRFU_CTRL_RST);
    rreg(`SRFU_ADDR_OPCOUNT, 8'h00);
    $display("test reset done");
    for (b = 0; b < 2; b++)
      for (v = 0; v < 3; v++)
        for (k = 1; k < 7; k++) begin
          f = b ? 8'h71 : 8'h00;
          wreg(`SRFU_ADDR_STATUS, f);
          op(k[4:0], 3'h0, pat[v]);
          x = ref_op(k[4:0], pat[v], f);
          chk(res, x[7:0]);
          chk(flags, x[15:8]);
          chk({6'h0, res_wr, pc_adv}, 8'h03);
        end
    $display("test shifts done");
    for (k = 0; k < 31; k++) begin
      set = k < 15 ? (!k[0] && k < 14) : k < 23;
      b = k < 15 ? pos[k >> 1] : (k - 15) % 8;
      c = k < 15 ? 5'h0b + k[4:0] : (set ? `SRFU_OP_FSET : `SRFU_OP_FCLR);
      wreg(`SRFU_ADDR_STATUS, set ? 8'h00 : 8'hff);
      op(c, b[2:0], 8'h00);
      e = 8'h01 << b;
      chk(flags, set ? e : ~e);
      chk({7'h0, res_wr}, 8'h00);
    end
    $display("test flags done");
    for (k = 0; k < 8; k++) begin
      wreg(`SRFU_ADDR_STATUS, 8'hbf);
      op(`SRFU_OP_BSTORE, k[2:0], 8'ha5);
      e = 8'ha5;
      chk(flags, {1'b1, e[k], 6'h3f});
    end
    wreg(`SRFU_ADDR_STATUS, 8'h40);
    op(`SRFU_OP_BLOAD, 3'h3, 8'h00);
    chk(res, 8'h08);
    chk(flags, 8'h40);
    wreg(`SRFU_ADDR_STATUS, 8'hbf);
    op(`SRFU_OP_BLOAD, 3'h3, 8'hff);
    chk(res, 8'hf7);
    chk(flags, 8'hbf);
    wreg(`SRFU_ADDR_RESULT, 8'h00);
    rreg(`SRFU_ADDR_RESULT, 8'hf7);
    $display("test bit ops done");
    wreg(`SRFU_ADDR_STATUS, 8'h5a);
    ctl(`SRFU_OP_SLEEP, 4'b1001);
    ctl(`SRFU_OP_WDOG, 4'b0101);
    ctl(`SRFU_OP_BREAK, 4'b0010);
    wreg(`SRFU_ADDR_CTRL, 8'h00);
    ctl(`SRFU_OP_BREAK, 4'b0001);
    ctl(`SRFU_OP_NOP, 4'b0001);
    // an unknown code with a flag write in the same cycle: the op wins
    fork
      op(5'h1d, 3'h0, 8'h00);
      begin
        repeat (2) @(posedge clk_in);
        wr <= 1;
        addr <= `SRFU_ADDR_STATUS;
        wdata <= 8'hff;
        @(posedge clk_in);
        wr <= 0;
      end
    join
    chk(flags, 8'h5a);
    chk({6'h0, res_wr, pc_adv}, 8'h01);
    @(posedge clk_in);
    ce_in <= 0;
    op(`SRFU_OP_ROTL, 3'h0, 8'h81);
    chk(flags, 8'h5a);
    chk({7'h0, res_wr}, 8'h00);
    @(posedge clk_in);
    ce_in <= 1;
    rreg(`SRFU_ADDR_OPCOUNT, 8'h53);
    $display("test control done");
    @(posedge clk_in);
    reset_in <= 1;
    @(posedge clk_in);
    reset_in <= 0;
    rreg(`SRFU_ADDR_STATUS, `SRFU_STATUS_RST);
    rreg(`SRFU_ADDR_CTRL, `SRFU_CTRL_RST);
    rreg(`SRFU_ADDR_OPCOUNT, 8'h00);
    $display("test second reset done");
    report_and_stop;
  end
endmodule // srfu_core_tb
